//--- src/ccsi_top.sv
/*
 Coupler control and safety interlock: drives the external coupling network
 and gates high voltage, load power and run state from the interlock loop.
 Assumes an AHB-Lite master with single word transfers, bus inputs synchronous
 to sys_clk_in, and comparators outside that turn loop voltages to levels.
*/
// The register addresses and the AHB-Lite slave port were decided locally.
// Summary of operation
// RULE_01 - Five coupling-select outputs, active high
// RULE_02 - Load power output follows load setting
// RULE_03 - Lamp colour output set by software
// RULE_04 - Phase-count high forbids phases two, three
// RULE_05 - Overheat blocks load power, raises message
// RULE_06 - Limit inputs clamp maximum burst voltage
// RULE_07 - Most restrictive condition always wins
// RULE_08 - Refuse run or pause with loop open
// RULE_09 - Loop opening while running forces stop
// RULE_10 - Refuse load power with loop open
// RULE_11 - Loop opening drops load power
// RULE_12 - Closed loop: green off, red on
// RULE_13 - Emergency stop opens loop, removes power
// RULE_14 - Enable only when all units safe
// RULE_15 - Interlock loop signals are active low
// RULE_16 - Break pass-through on stop or interlock
// RULE_17 - Open contact or high input inhibits
// RULE_18 - Status line voltage engages interlock
// RULE_19 - Standby to on activates lamp, peripherals
// RULE_20 - Report status, provide chained interlock output
// RULE_21 - Stop keeps high voltage off
// RULE_22 - Synchronise and debounce external inputs
`timescale 1ns/10ps
`include "ccsi_defines.svh"

module ccsi_top #(
	parameter int DEB_CYC = `CCSI_DEBOUNCE_CYC
) (
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic sys_rst_in,
	// AHB-Lite slave
	input wire logic hsel_in,
	input wire logic [7:0] haddr_in,
	input wire logic [1:0] htrans_in,
	input wire logic hwrite_in,
	input wire logic [2:0] hsize_in,
	input wire logic [31:0] hwdata_in,
	input wire logic hready_in,
	output logic [31:0] hrdata_out,
	output logic hreadyout_out,
	output logic hresp_out,
	// Coupling network
	input wire ccsi_pkg::ccsi_net_in_type net_in,
	output ccsi_pkg::ccsi_net_out_type net_out,
	output logic overheat_msg_out,
	// Interlock loop, inputs active low
	input wire logic loop_in_n_in,
	input wire logic estop_n_in,
	input wire logic ilk_status_n_in,
	output ccsi_pkg::ccsi_ilk_out_type ilk_out,
	// Operating state and high voltage
	output ccsi_pkg::ccsi_state_type state_out,
	output logic [12:0] volt_set_out
);
	import ccsi_pkg::*;

	localparam int NIN = 7;
	localparam int DW = $clog2(DEB_CYC + 1);

	// Count of equal samples needed before a debounced input changes
	function automatic logic deb_done(input logic [DW-1:0] cnt);
		deb_done = (cnt == DW'(DEB_CYC - 1));
	endfunction

	// Voltage ceiling for the two limit inputs
	function automatic logic [12:0] vmax_of(input logic first,
		input logic second);
		unique case ({first, second})
			2'b00: vmax_of = `CCSI_VMAX_NONE;
			2'b01: vmax_of = `CCSI_VMAX_SECOND;
			2'b10: vmax_of = `CCSI_VMAX_FIRST;
			2'b11: vmax_of = `CCSI_VMAX_BOTH;
		endcase
	endfunction

	// Raw inputs, active low loop signals taken without inversion
	wire logic [NIN-1:0] raw_in;
	assign raw_in = {net_in.overheat, net_in.single_phase_select,
		net_in.volt_limit_first, net_in.volt_limit_second,
		loop_in_n_in, estop_n_in, ilk_status_n_in}; // RULE_15

	// Two-flop synchronisers and debounce counters
	logic [NIN-1:0] sync1_r;
	logic [NIN-1:0] sync2_r;
	logic [NIN-1:0] deb_r;
	logic [DW-1:0] deb_cnt_r [NIN];
	always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			sync1_r <= 7'h07;
			sync2_r <= 7'h07;
		end else begin
			sync1_r <= raw_in;
			sync2_r <= sync1_r; // RULE_22
		end
	end

	// Reset leaves the loop inputs high, so the loop starts open
	for (genvar i = 0; i < NIN; i++) begin : g_deb
		always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
			if (sys_rst_in) begin
				deb_r[i] <= (i < 3) ? 1'b1 : 1'b0;
				deb_cnt_r[i] <= '0;
			end else if (sync2_r[i] == deb_r[i]) begin
				deb_cnt_r[i] <= '0;
			end else if (deb_done(deb_cnt_r[i])) begin
				deb_r[i] <= sync2_r[i]; // RULE_22
				deb_cnt_r[i] <= '0;
			end else begin
				deb_cnt_r[i] <= deb_cnt_r[i] + DW'(1);
			end
		end
	end

	// Debounced levels
	wire logic overheat;
	wire logic one_phase;
	wire logic lim_first;
	wire logic lim_second;
	wire logic loop_in_ok;
	wire logic estop_free;
	wire logic status_on;
	assign overheat = deb_r[6];
	assign one_phase = deb_r[5];
	assign lim_first = deb_r[4];
	assign lim_second = deb_r[3];
	assign loop_in_ok = ~deb_r[2]; // RULE_17
	assign estop_free = deb_r[1]; // RULE_13
	assign status_on = ~deb_r[0]; // RULE_18

	// Software registers
	logic load_req_r;
	logic lamp_r;
	logic power_on_r;
	logic [4:0] couple_r;
	logic [12:0] volt_req_r;
	logic [1:0] cmd_r;
	logic cmd_vld_r;
	ccsi_state_type state_r;
	ccsi_state_type state_nxt;

	// Loop is closed only when every unit in the chain is safe
	wire logic loop_closed;
	assign loop_closed = loop_in_ok & estop_free & status_on; // RULE_14

	// Restrictions, the most severe always applied
	wire logic [4:0] allowed_lines;
	wire logic [12:0] vmax;
	wire logic load_ok;
	assign allowed_lines = one_phase ? `CCSI_LINES_1PH_MASK : 5'h1F; // RULE_04
	assign vmax = vmax_of(lim_first, lim_second); // RULE_06
	assign load_ok = loop_closed & ~overheat; // RULE_07

	// Operating state machine
	always_comb begin
		state_nxt = state_r;
		if (cmd_vld_r) begin
			unique case (cmd_r)
				`CCSI_CMD_RUN: state_nxt = CCSI_RUN;
				`CCSI_CMD_PAUSE: state_nxt = CCSI_PAUSE;
				default: state_nxt = CCSI_STOP;
			endcase
		end
		if (!loop_closed) begin
			state_nxt = CCSI_STOP; // RULE_08 RULE_09
		end
	end

	always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			state_r <= CCSI_STOP;
		end else begin
			state_r <= state_nxt;
		end
	end

	// AHB-Lite address phase capture
	logic dp_wr_r;
	logic dp_rd_r;
	logic [7:0] dp_addr_r;
	wire logic take;
	assign take = hsel_in & htrans_in[1] & hready_in;
	always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			dp_wr_r <= 1'b0;
			dp_rd_r <= 1'b0;
			dp_addr_r <= 8'h00;
		end else begin
			dp_wr_r <= take & hwrite_in;
			dp_rd_r <= take & ~hwrite_in;
			dp_addr_r <= haddr_in;
		end
	end

	// Write decode in the data phase
	wire logic wr_ctrl;
	wire logic wr_couple;
	wire logic wr_volt;
	assign wr_ctrl = dp_wr_r & (dp_addr_r == `CCSI_OFS_CTRL);
	assign wr_couple = dp_wr_r & (dp_addr_r == `CCSI_OFS_COUPLE);
	assign wr_volt = dp_wr_r & (dp_addr_r == `CCSI_OFS_VOLT);

	// Load power falls at once when the loop opens or overheat rises
	always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			load_req_r <= 1'b0;
			lamp_r <= 1'b0;
			power_on_r <= 1'b0;
			couple_r <= 5'h00;
			volt_req_r <= 13'h0000;
			cmd_r <= `CCSI_CMD_STOP;
			cmd_vld_r <= 1'b0;
		end else begin
			cmd_vld_r <= wr_ctrl;
			if (wr_ctrl) begin
				load_req_r <= hwdata_in[`CCSI_CTRL_LOAD_BIT] & load_ok; // RULE_10
				lamp_r <= hwdata_in[`CCSI_CTRL_LAMP_BIT]; // RULE_03
				power_on_r <= hwdata_in[`CCSI_CTRL_ON_BIT];
				cmd_r <= hwdata_in[`CCSI_CTRL_CMD_MSB:`CCSI_CTRL_CMD_LSB];
			end else if (!load_ok) begin
				load_req_r <= 1'b0; // RULE_11 RULE_05
			end
			if (wr_couple) begin
				couple_r <= hwdata_in[4:0];
			end
			if (wr_volt) begin
				volt_req_r <= hwdata_in[12:0];
			end
		end
	end

	// Outputs held in flip-flops
	ccsi_net_out_type net_r;
	ccsi_ilk_out_type ilk_r;
	logic [12:0] volt_r;
	always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			net_r <= '0;
			ilk_r <= 4'h8;
			volt_r <= 13'h0000;
		end else begin
			net_r.coupling_line_select <= couple_r & allowed_lines; // RULE_01
			net_r.load_power_switch <= load_req_r & load_ok; // RULE_02
			// Closed loop forces red; software picks otherwise
			net_r.lamp_colour_select <= lamp_r & ~loop_closed; // RULE_12
			ilk_r.loop_pass_n <= ~(estop_free & status_on); // RULE_16
			ilk_r.lamp_periph_en <= power_on_r; // RULE_19
			ilk_r.hv_enable <= loop_closed & (state_nxt != CCSI_STOP); // RULE_21
			ilk_r.loop_closed <= loop_closed; // RULE_20
			volt_r <= (volt_req_r > vmax) ? vmax : volt_req_r; // RULE_06
		end
	end

	assign net_out = net_r;
	assign ilk_out = ilk_r;
	assign state_out = state_r;
	assign volt_set_out = volt_r;
	assign overheat_msg_out = overheat; // RULE_05

	// Read mux, unmapped addresses read zero
	logic [31:0] rd_mux;
	always_comb begin
		unique case (dp_addr_r)
			`CCSI_OFS_CTRL: rd_mux = {23'h0, power_on_r, 2'h0, cmd_r, 2'h0,
				lamp_r, load_req_r};
			`CCSI_OFS_COUPLE: rd_mux = {27'h0, net_r.coupling_line_select};
			`CCSI_OFS_VOLT: rd_mux = {19'h0, volt_r};
			`CCSI_OFS_STATUS: rd_mux = {24'h0, state_r, overheat, one_phase,
				loop_closed, estop_free, status_on, net_r.load_power_switch};
			`CCSI_OFS_VMAX: rd_mux = {19'h0, vmax};
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	assign hrdata_out = dp_rd_r ? rd_mux : 32'h0000_0000;
	assign hreadyout_out = 1'b1;
	assign hresp_out = 1'b0;

endmodule

//--- src/ccsi_defines.svh
/*
 Holds the constants of the coupler control and safety interlock block:
 register offsets, field positions, voltage ceilings and timing counts.
 Assumes inclusion by bare name from the package and the design module.
*/
`ifndef CCSI_DEFINES_SVH
`define CCSI_DEFINES_SVH

// Register byte offsets
`define CCSI_OFS_CTRL 8'h00
`define CCSI_OFS_COUPLE 8'h04
`define CCSI_OFS_VOLT 8'h08
`define CCSI_OFS_STATUS 8'h0C
`define CCSI_OFS_VMAX 8'h10

// Control register fields
`define CCSI_CTRL_LOAD_BIT 0
`define CCSI_CTRL_LAMP_BIT 1
`define CCSI_CTRL_CMD_LSB 4
`define CCSI_CTRL_CMD_MSB 5
`define CCSI_CTRL_ON_BIT 8

// Run command codes in the control register
`define CCSI_CMD_STOP 2'h0
`define CCSI_CMD_RUN 2'h1
`define CCSI_CMD_PAUSE 2'h2

// Coupling line bit positions
`define CCSI_LINE_EARTH 0
`define CCSI_LINE_PH1 1
`define CCSI_LINE_NEUTRAL 2
`define CCSI_LINE_PH2 3
`define CCSI_LINE_PH3 4
`define CCSI_LINES_1PH_MASK 5'h07

// Burst voltage ceilings in volts
`define CCSI_VMAX_NONE 13'h12C0
`define CCSI_VMAX_SECOND 13'h1194
`define CCSI_VMAX_FIRST 13'h05DC
`define CCSI_VMAX_BOTH 13'h01F4

// Input debounce time and its cycle count at 250 MHz
`define CCSI_DEBOUNCE_NS 1000
`define CCSI_CLK_PERIOD_NS 4
`define CCSI_DEBOUNCE_CYC (`CCSI_DEBOUNCE_NS / `CCSI_CLK_PERIOD_NS)

`endif

//--- src/ccsi_pkg.sv
/*
 Holds the types of the coupler control and safety interlock block.
 Assumes the constants header sits on the include path.
*/
`include "ccsi_defines.svh"

package ccsi_pkg;

	// Generator operating state
	typedef enum logic [1:0] {
		CCSI_STOP,
		CCSI_RUN,
		CCSI_PAUSE
	} ccsi_state_type;

	// Inputs from the external coupling network
	typedef struct packed {
		logic overheat;
		logic single_phase_select;
		logic volt_limit_first;
		logic volt_limit_second;
	} ccsi_net_in_type;

	// Outputs to the external coupling network
	typedef struct packed {
		logic [4:0] coupling_line_select;
		logic load_power_switch;
		logic lamp_colour_select;
	} ccsi_net_out_type;

	// Interlock loop outputs
	typedef struct packed {
		logic loop_pass_n;
		logic lamp_periph_en;
		logic hv_enable;
		logic loop_closed;
	} ccsi_ilk_out_type;

endpackage

//--- testbench/ccsi_top_sva.sv
/*
 Checker on the ports of the coupler control block.
 Assumes one clock, async high reset, inputs debounced within 8 cycles.
*/
`timescale 1ns/10ps
module ccsi_top_sva #(
	parameter int DEB_CYC = 2
) (
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic sys_rst_in,
	// Watched ports
	input wire ccsi_pkg::ccsi_net_in_type net_in,
	input wire ccsi_pkg::ccsi_net_out_type net_out,
	input wire logic overheat_msg_out,
	input wire logic loop_in_n_in,
	input wire logic estop_n_in,
	input wire ccsi_pkg::ccsi_ilk_out_type ilk_out,
	input wire ccsi_pkg::ccsi_state_type state_out,
	input wire logic [12:0] volt_set_out
);
	import ccsi_pkg::*;
	// Ceiling chosen by the two limit inputs
	wire logic [12:0] vceil = net_in.volt_limit_first ?
		(net_in.volt_limit_second ? 13'h01F4 : 13'h05DC) :
		(net_in.volt_limit_second ? 13'h1194 : 13'h12C0);
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (sys_rst_in);
	// Eight held cycles outlast sync plus debounce plus output flop
	AST_PH_MASK: assert property (net_in.single_phase_select [*8] |->
		net_out.coupling_line_select[4:3] == 2'h0)
		else $error("phase two or three selected");
	AST_VMAX: assert property ($stable(net_in) [*8] |->
		volt_set_out <= vceil) else $error("voltage above ceiling");
	AST_HV_STATE: assert property (ilk_out.hv_enable |->
		state_out != CCSI_STOP) else $error("high voltage in stop");
	AST_LAMP_RED: assert property (ilk_out.loop_closed [*3] |->
		!net_out.lamp_colour_select) else $error("lamp green, loop closed");
	AST_LOOP_STOP: assert property (loop_in_n_in [*8] |->
		state_out == CCSI_STOP && !ilk_out.hv_enable)
		else $error("not stopped with loop open");
	AST_LOOP_LOAD: assert property (loop_in_n_in [*8] |->
		!net_out.load_power_switch) else $error("load on, loop open");
	AST_ESTOP: assert property (!estop_n_in [*8] |->
		ilk_out.loop_pass_n && !ilk_out.hv_enable &&
		!net_out.load_power_switch) else $error("stop button ignored");
	AST_OVERHEAT: assert property (net_in.overheat [*8] |->
		overheat_msg_out && !net_out.load_power_switch)
		else $error("overheat ignored");
	// Main scenarios reached
	COV_RUN: cover property (state_out == CCSI_RUN);
	COV_PAUSE: cover property (state_out == CCSI_PAUSE);
	COV_LOAD: cover property (net_out.load_power_switch);
endmodule

bind ccsi_top ccsi_top_sva #(.DEB_CYC(DEB_CYC)) sva_u (
	.sys_clk_in(sys_clk_in),
	.sys_rst_in(sys_rst_in),
	.net_in(net_in),
	.net_out(net_out),
	.overheat_msg_out(overheat_msg_out),
	.loop_in_n_in(loop_in_n_in),
	.estop_n_in(estop_n_in),
	.ilk_out(ilk_out),
	.state_out(state_out),
	.volt_set_out(volt_set_out)
);

//--- testbench/ccsi_net_model.sv
/*
 Coupling network and chained interlock contacts seen from the block.
 Assumes the bench sets conditions: [5] hot [4] 1ph [3:2] limits
 [1] contact open [0] stop pressed.
*/
`timescale 1ns/10ps
module ccsi_net_model (
	// Conditions from the bench
	input wire logic [5:0] env_in,
	// Lines towards the block
	output ccsi_pkg::ccsi_net_in_type net_out,
	output logic loop_n_out,
	output logic estop_n_out,
	output logic stat_n_out
);
	import ccsi_pkg::*;
	// Network levels, active high
	assign net_out = env_in[5:2];
	// Series contacts: any open one lets the loop line float high
	assign loop_n_out = env_in[1] | env_in[0];
	assign estop_n_out = ~env_in[0];
	// Status voltage only while the [1] contact is closed
	assign stat_n_out = env_in[1];
endmodule

//--- testbench/ccsi_top_tb.sv
/*
 Self-checking bench for the coupler control block.
 Assumes DEB_CYC of 2, so 12 cycles cover any input settling.
*/
`timescale 1ns/10ps
module ccsi_top_tb;
	import ccsi_pkg::*;
	typedef struct packed {
		logic [2:0] c;
		logic [4:0] cpl;
		logic [12:0] v;
		logic [4:0] ecpl;
		logic [12:0] ev;
	} ccsi_row_type;
	logic sys_clk_in, sys_rst_in, hsel, hwrite;
	logic [7:0] haddr;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] hwdata, q;
	logic [5:0] env;
	wire logic [31:0] hrdata;
	wire logic hready, hresp, ohmsg, loop_n, estop_n, stat_n;
	wire ccsi_net_in_type net_in;
	wire ccsi_net_out_type net_out;
	wire ccsi_ilk_out_type ilk_out;
	wire ccsi_state_type state;
	wire logic [12:0] volt;
	// State, load, lamp and interlock outputs side by side
	wire logic [12:0] st = {5'h0, state, net_out.load_power_switch,
		net_out.lamp_colour_select, ilk_out};
	int bad_count = 0;
	int samples_checked = 0;
	int tick = 0;
	// Limits {1ph, first, second}, select, voltage, expected
	ccsi_row_type rows [5] = '{
		'{3'h0, 5'h1F, 13'h1400, 5'h1F, 13'h12C0},
		'{3'h5, 5'h1F, 13'h1200, 5'h07, 13'h1194},
		'{3'h2, 5'h18, 13'h0800, 5'h18, 13'h05DC},
		'{3'h3, 5'h0A, 13'h0300, 5'h0A, 13'h01F4},
		'{3'h4, 5'h08, 13'h01F4, 5'h00, 13'h01F4}};

	ccsi_top #(.DEB_CYC(2)) dut_u (.sys_clk_in(sys_clk_in),
		.sys_rst_in(sys_rst_in), .hsel_in(hsel), .haddr_in(haddr),
		.htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize),
		.hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata),
		.hreadyout_out(hready), .hresp_out(hresp), .net_in(net_in),
		.net_out(net_out), .overheat_msg_out(ohmsg),
		.loop_in_n_in(loop_n), .estop_n_in(estop_n),
		.ilk_status_n_in(stat_n), .ilk_out(ilk_out), .state_out(state),
		.volt_set_out(volt));
	ccsi_net_model mdl_u (.env_in(env), .net_out(net_in),
		.loop_n_out(loop_n), .estop_n_out(estop_n), .stat_n_out(stat_n));

	task automatic chk(input logic [12:0] g, e, m);
		samples_checked++;
		if ((g & m) !== e) begin
			bad_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g & m, e);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk_in);
	endtask
	// Read data taken at the edge that samples hready high
	task automatic wait_rdy();
		do begin
			@(posedge sys_clk_in);
			q = hrdata;
		end while (hready !== 1'b1);
	endtask
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge sys_clk_in);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		wait_rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy();
	endtask
	task automatic close_out();
		$display("checked %0d bad %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// Clock, 4 ns period
	initial begin
		sys_clk_in = 1'b0;
		forever #2 sys_clk_in = ~sys_clk_in;
	end
	// Hang guard, run needs well under a thousand cycles
	always @(posedge sys_clk_in) begin
		tick++;
		if (tick == 5000) begin
			bad_count++;
			close_out();
		end
	end
	// Rows first, then interlock sequences
	initial begin
		sys_rst_in = 1'b1;
		hsel = 1'b0;
		haddr = 8'h00;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		env = 6'h00;
		cyc(3);
		chk(st, 13'h008, 13'h0FF);
		sys_rst_in <= 1'b0;
		cyc(12);
		foreach (rows[i]) begin
			env <= {1'b0, rows[i].c, 2'h0};
			bus(1'b1, 8'h04, {27'h0, rows[i].cpl});
			bus(1'b1, 8'h08, {19'h0, rows[i].v});
			cyc(12);
			chk({8'h0, net_out.coupling_line_select},
				{8'h0, rows[i].ecpl}, 13'h1FFF);
			chk(volt, rows[i].ev, 13'h1FFF);
		end
		env <= 6'h02;
		cyc(12);
		bus(1'b1, 8'h00, 32'h0000_0011);
		cyc(6);
		chk(st, 13'h000, 13'h0F7);
		env <= 6'h00;
		cyc(12);
		bus(1'b1, 8'h00, 32'h0000_0113);
		cyc(6);
		chk(st, 13'h067, 13'h0FF);
		env <= 6'h02;
		cyc(12);
		chk(st, 13'h000, 13'h0E3);
		env <= 6'h00;
		cyc(12);
		bus(1'b1, 8'h00, 32'h0000_0121);
		cyc(6);
		chk(st, 13'h0A7, 13'h0FF);
		env <= 6'h01;
		cyc(12);
		chk(st, 13'h008, 13'h0EB);
		env <= 6'h20;
		cyc(12);
		bus(1'b1, 8'h00, 32'h0000_0001);
		cyc(6);
		chk({11'h0, ohmsg, st[5]}, 13'h002, 13'h003);
		env <= 6'h02;
		bus(1'b1, 8'h00, 32'h0000_0002);
		cyc(12);
		chk(st, 13'h010, 13'h010);
		env <= 6'h00;
		cyc(12);
		chk(st, 13'h000, 13'h010);
		bus(1'b0, 8'h0C, 32'h0);
		chk(q[12:0], 13'h008, 13'h008);
		bus(1'b0, 8'h40, 32'h0);
		chk(q[12:0], 13'h000, 13'h1FFF);
		close_out();
	end
endmodule
